/* File: rtl/dirm_pkg.sv */
package dirm_pkg;

  // ----------------------------------------------------------------
  // Message layout
  // ----------------------------------------------------------------
  localparam int ID_W     = 4;
  localparam int DATA_W   = 16;
  localparam int PAY_W    = ID_W + DATA_W;
  localparam int CRC_W    = 32;
  localparam int FRAME_W  = PAY_W + CRC_W;
  localparam int PEER_MAX = 16;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] TX_BITS = BIT_CNT_W'(FRAME_W + 2);
  localparam logic [BIT_CNT_W-1:0] RX_LAST = BIT_CNT_W'(FRAME_W - 1);

  localparam logic [CRC_W-1:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'hFFFFFFFF;

  // ----------------------------------------------------------------
  // Interface kinds and line rates
  // ----------------------------------------------------------------
  localparam logic [1:0] IFACE_FIBER = 2'h0;
  localparam logic [1:0] IFACE_G703  = 2'h1;
  localparam logic [1:0] IFACE_RS422 = 2'h2;

  localparam int CLK_HZ        = 50_000_000;
  localparam int RATE_FAST_BPS = 128_000;
  localparam int RATE_SLOW_BPS = 64_000;
  localparam int BAUD_W        = 10;
  localparam logic [BAUD_W-1:0] BIT_FAST_CYC = BAUD_W'(CLK_HZ / RATE_FAST_BPS);
  localparam logic [BAUD_W-1:0] BIT_SLOW_CYC = BAUD_W'(CLK_HZ / RATE_SLOW_BPS);

  // ----------------------------------------------------------------
  // Supervision timing, counted in milliseconds
  // ----------------------------------------------------------------
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int MSCNT_W       = 12;
  localparam logic [MSCNT_W-1:0] INTEGRITY_MS  = 12'h3E8;
  localparam logic [MSCNT_W-1:0] INTEG_MARGIN  = 12'h002;
  localparam logic [MSCNT_W-1:0] INTEG_TRIG_MS = INTEGRITY_MS - INTEG_MARGIN;
  localparam logic [MSCNT_W-1:0] OFFLINE_MS    = 12'h7D0;
  localparam logic [MSCNT_W-1:0] RETURN_MS     = 12'h7D0;
  localparam logic [MSCNT_W-1:0] MSCNT_MAX     = 12'hFFF;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} dirm_rx_e;

  function automatic logic [CRC_W-1:0] dirm_crc32(input logic [PAY_W-1:0] d);
    logic [CRC_W-1:0] c;
    c = CRC_INIT;
    for (int i = 0; i < PAY_W; i++) begin
      if (c[CRC_W-1] ^ d[i]) begin
        c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[CRC_W-2:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic [FRAME_W-1:0] dirm_frame(input logic [ID_W-1:0] id,
                                                    input logic [DATA_W-1:0] data);
    return {dirm_crc32({data, id}), data, id};
  endfunction

endpackage

/* File: rtl/dirm_fifo.sv */
`timescale 1ns/1ns
module dirm_fifo
  import dirm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_comb begin
    in_ready    = (count != CW'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count  = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; count guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // dirm_fifo

/* File: rtl/dirm_ring_framer.sv */
`timescale 1ns/1ns
module dirm_ring_framer
  import dirm_pkg::*;
#(
  parameter int NUM_PEERS  = PEER_MAX,
  parameter int MS_CYCLES  = MS_CYCLES_DEF,
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Configuration
  input  wire logic [ID_W-1:0]            sender_identifier,
  input  wire logic                       dual_channel,
  input  wire logic                       ring_mode,
  input  wire logic                       rate_fast_sel,
  input  wire logic [1:0]                 iface_type,
  input  wire logic                       channel_bridge_enable,
  // Local status to send
  input  wire logic [DATA_W-1:0]          status_in,
  // Serial lines
  output logic [1:0]                      tx_line,
  input  wire logic [1:0]                 rx_line,
  // Received messages
  output logic [1:0]                      rx_valid,
  output logic [1:0][ID_W-1:0]            rx_sender,
  output logic [1:0][DATA_W-1:0]          rx_data,
  // Supervision
  output logic                            rate_fast,
  output logic                            ring_break,
  output logic [NUM_PEERS-1:0]            peer_offline,
  output logic [1:0]                      crc_error,
  output logic [1:0]                      rx_overrun
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // ----------------------------------------------------------------
  // Rate, millisecond tick and local message requests
  // ----------------------------------------------------------------
  logic [1:0]          ch_en;
  logic [BAUD_W-1:0]   bit_cyc;
  logic [MS_W-1:0]     ms_cnt;
  logic [MS_W-1:0]     next_ms_cnt;
  logic                ms_tick;
  logic                next_ms_tick;
  logic                next_rate_fast;
  logic [DATA_W-1:0]   status_q;
  logic [MSCNT_W-1:0]  integ_ms;
  logic [MSCNT_W-1:0]  next_integ_ms;
  logic [1:0]          local_pend;
  logic [1:0]          next_local_pend;
  logic [1:0]          launch_local;
  logic                local_req;

  always_comb begin
    ch_en          = {dual_channel, 1'b1};
    bit_cyc        = rate_fast ? BIT_FAST_CYC : BIT_SLOW_CYC;
    next_rate_fast = rate_fast_sel && (iface_type == IFACE_FIBER);
    next_ms_tick   = (ms_cnt == MS_W'(MS_CYCLES - 1));
    next_ms_cnt    = next_ms_tick ? '0 : ms_cnt + MS_W'(1);
    local_req      = (status_in != status_q) || (integ_ms >= INTEG_TRIG_MS);
    if (local_req) begin
      next_integ_ms = '0;
    end else if (ms_tick && integ_ms != MSCNT_MAX) begin
      next_integ_ms = integ_ms + MSCNT_W'(1);
    end else begin
      next_integ_ms = integ_ms;
    end
    // A request arriving in the launch cycle wins over the clear.
    next_local_pend = ch_en & ({2{local_req}} | (local_pend & ~launch_local));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_fast  <= 1'b0;
      ms_cnt     <= '0;
      ms_tick    <= 1'b0;
      status_q   <= '0;
      integ_ms   <= '0;
      local_pend <= '0;
    end else begin
      rate_fast  <= next_rate_fast;
      ms_cnt     <= next_ms_cnt;
      ms_tick    <= next_ms_tick;
      status_q   <= status_in;
      integ_ms   <= next_integ_ms;
      local_pend <= next_local_pend;
    end
  end

  // ----------------------------------------------------------------
  // Forwarding buffers, one per transmit channel
  // ----------------------------------------------------------------
  logic [1:0]          buf_in_valid;
  logic [1:0]          buf_in_ready;
  logic [FRAME_W-1:0]  buf_in_data [2];
  logic [1:0]          buf_out_valid;
  logic [1:0]          buf_out_ready;
  logic [FRAME_W-1:0]  buf_out_data [2];
  logic [1:0]          hold_valid;
  logic [FRAME_W-1:0]  hold_frame [2];
  logic [1:0]          hold_taken;
  logic                bridge_on;

  always_comb begin
    bridge_on       = channel_bridge_enable && dual_channel;
    buf_in_valid[0] = hold_valid[0] && !bridge_on;
    buf_in_data[0]  = hold_frame[0];
    buf_in_valid[1] = hold_valid[1] || (hold_valid[0] && bridge_on);
    buf_in_data[1]  = hold_valid[1] ? hold_frame[1] : hold_frame[0];
    hold_taken[1]   = hold_valid[1] && buf_in_ready[1];
    hold_taken[0]   = hold_valid[0] && (bridge_on ? (buf_in_ready[1] && !hold_valid[1])
                                                  : buf_in_ready[0]);
  end

  for (genvar g = 0; g < 2; g++) begin : g_fwd
    dirm_fifo #(
      .WIDTH (FRAME_W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (buf_in_valid[g]),
      .in_ready  (buf_in_ready[g]),
      .in_data   (buf_in_data[g]),
      .out_valid (buf_out_valid[g]),
      .out_ready (buf_out_ready[g]),
      .out_data  (buf_out_data[g])
    );
  end

  // ----------------------------------------------------------------
  // Transmitters: start bit, frame LSB first, stop bit
  // ----------------------------------------------------------------
  logic [1:0]                 tx_busy;
  logic [1:0]                 next_tx_busy;
  logic [TX_BITS-1:0]         tx_sh [2];
  logic [TX_BITS-1:0]         next_tx_sh [2];
  logic [BIT_CNT_W-1:0]       tx_bits [2];
  logic [BIT_CNT_W-1:0]       next_tx_bits [2];
  logic [BAUD_W-1:0]          tx_baud [2];
  logic [BAUD_W-1:0]          next_tx_baud [2];
  logic [1:0]                 next_tx_line;
  logic [FRAME_W-1:0]         local_frame;

  always_comb begin
    local_frame = dirm_frame(sender_identifier, status_in);
    for (int c = 0; c < 2; c++) begin
      next_tx_busy[c]  = tx_busy[c];
      next_tx_sh[c]    = tx_sh[c];
      next_tx_bits[c]  = tx_bits[c];
      next_tx_baud[c]  = tx_baud[c];
      next_tx_line[c]  = tx_line[c];
      launch_local[c]  = 1'b0;
      // Local traffic goes first so the integrity deadline cannot slip behind forwarding.
      buf_out_ready[c] = !tx_busy[c] && !local_pend[c] && ch_en[c];
      if (!tx_busy[c]) begin
        next_tx_line[c] = 1'b1;
        if (local_pend[c]) begin
          launch_local[c] = 1'b1;
          next_tx_sh[c]   = {1'b1, local_frame, 1'b0};
        end else if (buf_out_valid[c] && ch_en[c]) begin
          next_tx_sh[c]   = {1'b1, buf_out_data[c], 1'b0};
        end
        if (launch_local[c] || buf_out_ready[c] && buf_out_valid[c]) begin
          next_tx_busy[c] = 1'b1;
          next_tx_bits[c] = TX_BITS;
          next_tx_baud[c] = bit_cyc - BAUD_W'(1);
          next_tx_line[c] = 1'b0;
        end
      end else if (tx_baud[c] != '0) begin
        next_tx_baud[c] = tx_baud[c] - BAUD_W'(1);
      end else if (tx_bits[c] == BIT_CNT_W'(1)) begin
        next_tx_busy[c] = 1'b0;
        next_tx_line[c] = 1'b1;
      end else begin
        next_tx_sh[c]   = {1'b1, tx_sh[c][TX_BITS-1:1]};
        next_tx_bits[c] = tx_bits[c] - BIT_CNT_W'(1);
        next_tx_baud[c] = bit_cyc - BAUD_W'(1);
        next_tx_line[c] = tx_sh[c][1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= '0;
      tx_line <= 2'h3;
      for (int c = 0; c < 2; c++) begin
        tx_sh[c]   <= '1;
        tx_bits[c] <= '0;
        tx_baud[c] <= '0;
      end
    end else begin
      tx_busy <= next_tx_busy;
      tx_line <= next_tx_line;
      for (int c = 0; c < 2; c++) begin
        tx_sh[c]   <= next_tx_sh[c];
        tx_bits[c] <= next_tx_bits[c];
        tx_baud[c] <= next_tx_baud[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receivers, CRC check and hand-off to the forwarding buffers
  // ----------------------------------------------------------------
  dirm_rx_e              rx_st [2];
  dirm_rx_e              next_rx_st [2];
  logic [BAUD_W-1:0]     rx_baud [2];
  logic [BAUD_W-1:0]     next_rx_baud [2];
  logic [BIT_CNT_W-1:0]  rx_bits [2];
  logic [BIT_CNT_W-1:0]  next_rx_bits [2];
  logic [FRAME_W-1:0]    rx_sh [2];
  logic [FRAME_W-1:0]    next_rx_sh [2];
  logic [1:0]            good;
  logic [1:0]            own;
  logic [1:0]            next_hold_valid;
  logic [FRAME_W-1:0]    next_hold_frame [2];
  logic [1:0]            next_rx_valid;
  logic [1:0]            next_crc_error;
  logic [1:0]            next_rx_overrun;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      next_rx_st[c]      = rx_st[c];
      next_rx_baud[c]    = rx_baud[c];
      next_rx_bits[c]    = rx_bits[c];
      next_rx_sh[c]      = rx_sh[c];
      good[c]            = 1'b0;
      next_crc_error[c]  = 1'b0;
      own[c]             = (rx_sh[c][ID_W-1:0] == sender_identifier);
      case (rx_st[c])
        RX_IDLE: begin
          if (!rx_line[c]) begin
            next_rx_st[c]   = RX_START;
            next_rx_baud[c] = bit_cyc >> 1;
          end
        end
        RX_START: begin
          if (rx_baud[c] != '0) begin
            next_rx_baud[c] = rx_baud[c] - BAUD_W'(1);
          end else begin
            // A glitch shorter than half a bit is not taken as a start bit.
            next_rx_st[c]   = rx_line[c] ? RX_IDLE : RX_DATA;
            next_rx_baud[c] = bit_cyc - BAUD_W'(1);
            next_rx_bits[c] = '0;
          end
        end
        RX_DATA: begin
          if (rx_baud[c] != '0) begin
            next_rx_baud[c] = rx_baud[c] - BAUD_W'(1);
          end else begin
            next_rx_sh[c]   = {rx_line[c], rx_sh[c][FRAME_W-1:1]};
            next_rx_baud[c] = bit_cyc - BAUD_W'(1);
            next_rx_bits[c] = rx_bits[c] + BIT_CNT_W'(1);
            if (rx_bits[c] == RX_LAST) begin
              next_rx_st[c] = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_baud[c] != '0) begin
            next_rx_baud[c] = rx_baud[c] - BAUD_W'(1);
          end else begin
            next_rx_st[c] = RX_IDLE;
            if (rx_line[c] &&
                dirm_crc32(rx_sh[c][PAY_W-1:0]) == rx_sh[c][FRAME_W-1:PAY_W]) begin
              good[c] = 1'b1;
            end else begin
              next_crc_error[c] = 1'b1;
            end
          end
        end
        default: next_rx_st[c] = RX_IDLE;
      endcase
      if (!ch_en[c]) begin
        next_rx_st[c] = RX_IDLE;
      end
      next_rx_valid[c]   = good[c] && !own[c];
      // A frame finishing while the hold slot is still occupied is dropped and reported.
      next_rx_overrun[c] = good[c] && !own[c] && hold_valid[c] && !hold_taken[c];
      next_hold_valid[c] = hold_valid[c] && !hold_taken[c];
      next_hold_frame[c] = hold_frame[c];
      if (good[c] && !own[c] && !next_hold_valid[c]) begin
        next_hold_valid[c] = 1'b1;
        next_hold_frame[c] = rx_sh[c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_valid <= '0;
      rx_valid   <= '0;
      crc_error  <= '0;
      rx_overrun <= '0;
      rx_sender  <= '0;
      rx_data    <= '0;
      for (int c = 0; c < 2; c++) begin
        rx_st[c]      <= RX_IDLE;
        rx_baud[c]    <= '0;
        rx_bits[c]    <= '0;
        rx_sh[c]      <= '0;
        hold_frame[c] <= '0;
      end
    end else begin
      hold_valid <= next_hold_valid;
      rx_valid   <= next_rx_valid;
      crc_error  <= next_crc_error;
      rx_overrun <= next_rx_overrun;
      for (int c = 0; c < 2; c++) begin
        rx_st[c]      <= next_rx_st[c];
        rx_baud[c]    <= next_rx_baud[c];
        rx_bits[c]    <= next_rx_bits[c];
        rx_sh[c]      <= next_rx_sh[c];
        hold_frame[c] <= next_hold_frame[c];
        if (next_rx_valid[c]) begin
          rx_sender[c] <= rx_sh[c][ID_W-1:0];
          rx_data[c]   <= rx_sh[c][PAY_W-1:ID_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Peer and ring supervision
  // ----------------------------------------------------------------
  logic [MSCNT_W-1:0]    peer_ms [NUM_PEERS];
  logic [MSCNT_W-1:0]    next_peer_ms [NUM_PEERS];
  logic [NUM_PEERS-1:0]  next_peer_offline;
  logic [MSCNT_W-1:0]    ret_ms;
  logic [MSCNT_W-1:0]    next_ret_ms;
  logic                  next_ring_break;
  logic                  own_ret;

  always_comb begin
    for (int p = 0; p < NUM_PEERS; p++) begin
      if ((next_rx_valid[0] && rx_sh[0][ID_W-1:0] == ID_W'(p)) ||
          (next_rx_valid[1] && rx_sh[1][ID_W-1:0] == ID_W'(p))) begin
        next_peer_ms[p] = '0;
      end else if (ms_tick && peer_ms[p] != MSCNT_MAX) begin
        next_peer_ms[p] = peer_ms[p] + MSCNT_W'(1);
      end else begin
        next_peer_ms[p] = peer_ms[p];
      end
      next_peer_offline[p] = (peer_ms[p] >= OFFLINE_MS);
    end
    own_ret = |(good & own);
    if (own_ret || !ring_mode) begin
      next_ret_ms = '0;
    end else if (ms_tick && ret_ms != MSCNT_MAX) begin
      next_ret_ms = ret_ms + MSCNT_W'(1);
    end else begin
      next_ret_ms = ret_ms;
    end
    next_ring_break = ring_mode && (ret_ms >= RETURN_MS);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_ms       <= '0;
      ring_break   <= 1'b0;
      peer_offline <= '0;
      for (int p = 0; p < NUM_PEERS; p++) begin
        peer_ms[p] <= '0;
      end
    end else begin
      ret_ms       <= next_ret_ms;
      ring_break   <= next_ring_break;
      peer_offline <= next_peer_offline;
      for (int p = 0; p < NUM_PEERS; p++) begin
        peer_ms[p] <= next_peer_ms[p];
      end
    end
  end

endmodule // dirm_ring_framer

/* File: dv/dirm_ring_framer_properties.sv */
`timescale 1ns/1ns
module dirm_ring_framer_properties
  import dirm_pkg::*;
#(
  parameter int NUM_PEERS = PEER_MAX
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Configuration
  input wire logic [ID_W-1:0]      sender_identifier,
  input wire logic                 dual_channel,
  input wire logic                 ring_mode,
  input wire logic                 rate_fast_sel,
  input wire logic [1:0]           iface_type,
  // Observed outputs
  input wire logic [1:0]           tx_line,
  input wire logic [1:0]           rx_valid,
  input wire logic [1:0][ID_W-1:0] rx_sender,
  input wire logic                 rate_fast,
  input wire logic                 ring_break,
  input wire logic [NUM_PEERS-1:0] peer_offline,
  input wire logic [1:0]           crc_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tx1_single_idle: assert property (!dual_channel |-> tx_line[1])
    else $error("second channel transmits in single mode");
  a_rx1_single_mute: assert property (!dual_channel |-> !rx_valid[1])
    else $error("second channel delivers in single mode");
  a_rate_slow_fixed: assert property (iface_type != IFACE_FIBER |=> !rate_fast)
    else $error("fast rate on non fiber interface");
  a_rate_fiber_sel: assert property (iface_type == IFACE_FIBER |=>
      rate_fast == $past(rate_fast_sel))
    else $error("fiber rate does not follow selection");
  a_own_ch0_kept: assert property (rx_valid[0] |-> rx_sender[0] != sender_identifier)
    else $error("own message delivered on channel 0");
  a_own_ch1_kept: assert property (rx_valid[1] |-> rx_sender[1] != sender_identifier)
    else $error("own message delivered on channel 1");
  a_break_needs_ring: assert property ($rose(ring_break) |-> $past(ring_mode))
    else $error("ring break raised outside ring mode");
  a_crc_no_valid: assert property ((crc_error & rx_valid) == 2'h0)
    else $error("corrupted message delivered");
  a_heard_online: assert property (rx_valid[0] |-> ##[1:3] !peer_offline[rx_sender[0]])
    else $error("heard peer still offline");
  a_valid_pulse: assert property (rx_valid[0] |=> !rx_valid[0])
    else $error("delivery pulse longer than one cycle");
endmodule // dirm_ring_framer_properties

bind dirm_ring_framer dirm_ring_framer_properties #(.NUM_PEERS(NUM_PEERS)) u_props (.*);

/* File: dv/dirm_peer_model.sv */
`timescale 1ns/1ns
module dirm_peer_model
  import dirm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Line toward the device
  output logic     line
);
  // A peer must run at the device's rate, here the fast fiber bit time.
  int bit_cyc = int'(BIT_FAST_CYC);

  initial line = 1'b1;

  function automatic logic [53:0] frm(input logic [ID_W-1:0] id, input logic [DATA_W-1:0] d,
                                      input logic bad);
    logic [CRC_W-1:0] c;
    logic [PAY_W-1:0] p;
    p = {d, id};
    c = CRC_INIT;
    for (int i = 0; i < PAY_W; i++) begin
      c = {c[CRC_W-2:0], 1'b0} ^ (c[CRC_W-1] ^ p[i] ? CRC_POLY : 32'h00000000);
    end
    return {1'b1, c ^ {31'h00000000, bad}, p, 1'b0};
  endfunction

  // The stop bit leaves the line high, which is also its idle level.
  task automatic send(input logic [ID_W-1:0] id, input logic [DATA_W-1:0] d, input logic bad);
    logic [53:0] f;
    f = frm(id, d, bad);
    for (int i = 0; i < 54; i++) begin
      @(negedge clk);
      line = f[i];
      repeat (bit_cyc - 1) @(negedge clk);
    end
  endtask
endmodule // dirm_peer_model

/* File: dv/dirm_ring_framer_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, e, a); end end
module dirm_ring_framer_tb
  import dirm_pkg::*;
;
  typedef struct {logic [1:0] ift; logic sel; logic exp;} dirm_row_s;
  dirm_row_s rows[6] = '{'{IFACE_FIBER, 1'b1, 1'b1}, '{IFACE_FIBER, 1'b0, 1'b0},
    '{IFACE_G703, 1'b1, 1'b0}, '{IFACE_RS422, 1'b1, 1'b0}, '{2'h3, 1'b1, 1'b0},
    '{IFACE_G703, 1'b0, 1'b0}};

  logic                   clk = 1'b0;
  logic                   rst_n, dual_channel, ring_mode, rate_fast_sel;
  logic                   channel_bridge_enable, rate_fast, ring_break, same;
  logic [ID_W-1:0]        sender_identifier;
  logic [1:0]             iface_type, tx_line, rx_valid, crc_error, rx_overrun;
  wire logic [1:0]        rx_line;
  logic [DATA_W-1:0]      status_in;
  logic [1:0][ID_W-1:0]   rx_sender;
  logic [1:0][DATA_W-1:0] rx_data;
  logic [PEER_MAX-1:0]    peer_offline;
  logic [53:0]            fr;
  int                     n_mismatch, checks_done, n_val0, n_val1, n_err1, n_ovr;

  always #10 clk = ~clk;

  dirm_ring_framer #(.MS_CYCLES(30)) dut_u (.*);
  dirm_peer_model p0 (.clk(clk), .line(rx_line[0]));
  dirm_peer_model p1 (.clk(clk), .line(rx_line[1]));

  always @(posedge clk) begin
    n_val0 += int'(rx_valid[0] === 1'b1);
    n_val1 += int'(rx_valid[1] === 1'b1);
    n_err1 += int'(crc_error[1] === 1'b1);
    n_ovr  += int'((|rx_overrun) === 1'b1);
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Samples one frame of channel 0 at bit centres, noting whether channel 1 matched it.
  task automatic grab(output logic [53:0] f, output logic eq);
    int n;
    n = 0;
    eq = 1'b1;
    while (tx_line[0] !== 1'b0 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60000) n_mismatch++;
    repeat (195) @(negedge clk);
    for (int i = 0; i < 54; i++) begin
      if (i > 0) repeat (390) @(negedge clk);
      f[i] = tx_line[0];
      if (tx_line[1] !== tx_line[0]) eq = 1'b0;
    end
  endtask

  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    dual_channel = 1'b0;
    ring_mode = 1'b1;
    rate_fast_sel = 1'b1;
    channel_bridge_enable = 1'b0;
    sender_identifier = 4'h3;
    iface_type = IFACE_FIBER;
    status_in = 16'h0000;
    repeat (12) @(negedge clk);
    `CHK("tx_line", 2'h3, tx_line)
    `CHK("ring_break", 1'b0, ring_break)
    `CHK("peer_offline", 16'h0000, peer_offline)
    rst_n = 1'b1;
    foreach (rows[k]) begin
      @(negedge clk);
      iface_type = rows[k].ift;
      rate_fast_sel = rows[k].sel;
      repeat (2) @(negedge clk);
      `CHK("rate_fast", rows[k].exp, rate_fast)
    end
    $display("test line_rate done");
    iface_type = IFACE_FIBER;
    rate_fast_sel = 1'b1;
    dual_channel = 1'b1;
    status_in = 16'hA5C3;
    fork
      begin
        grab(fr, same);
        `CHK("local_frame", p0.frm(4'h3, 16'hA5C3, 1'b0), fr)
        `CHK("both_channels", 1'b1, same)
        grab(fr, same);
        `CHK("forward_frame", p0.frm(4'h5, 16'h1234, 1'b0), fr)
        grab(fr, same);
        `CHK("integrity_frame", p0.frm(4'h3, 16'hA5C3, 1'b0), fr)
      end
      begin
        p0.send(4'h5, 16'h1234, 1'b0);
        repeat (2) @(negedge clk);
        `CHK("rx_sender", 4'h5, rx_sender[0])
        `CHK("rx_data", 16'h1234, rx_data[0])
        `CHK("valid_count", 1, n_val0)
      end
      begin
        p1.send(4'h6, 16'h0F0F, 1'b1);
        repeat (2) @(negedge clk);
        `CHK("crc_error_count", 1, n_err1)
        `CHK("bad_valid_count", 0, n_val1)
      end
    join
    $display("test traffic done");
    `CHK("offline_silent", 1'b1, peer_offline[9])
    `CHK("offline_heard", 1'b0, peer_offline[5])
    `CHK("ring_break_set", 1'b1, ring_break)
    // The own frame returns on channel 1 while channel 0 carries a bridged foreign frame.
    // Channel 1 is idle by then, so the bridged copy is already in its start bit on tx 1.
    channel_bridge_enable = 1'b1;
    fork
      p0.send(4'h7, 16'h5A5A, 1'b0);
      p1.send(4'h3, 16'h00FF, 1'b0);
    join
    repeat (3) @(negedge clk);
    `CHK("ring_break_clear", 1'b0, ring_break)
    `CHK("own_not_delivered", 0, n_val1)
    `CHK("bridged_delivered", 2, n_val0)
    `CHK("bridged_sender", 4'h7, rx_sender[0])
    `CHK("bridge_start_ch1", 1'b0, tx_line[1])
    `CHK("no_overrun", 0, n_ovr)
    $display("test supervision done");
    give_verdict();
  end
endmodule // dirm_ring_framer_tb
